/* File: addr_assign.sv */
/*
  Device address assignment for a daisy-chained monitor: stored address
  reload, serial auto-addressing and strap-pin addressing, with an
  Avalon-MM register slave. Assumes the chain receiver gives a one-cycle
  end-of-frame pulse on sys_clk and that strap pins are asynchronous.
*/
`timescale 1ns/1ns
`default_nettype none
module addr_assign
  import addr_assign_pkg::*;
#(
  parameter logic [addr_assign_pkg::ADDR_W-1:0] STORED_INIT = addr_assign_pkg::STORED_ADDR_RESET
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Avalon-MM slave
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Chain receiver frame report
  input wire logic frameEnd,
  input wire logic frameHasAddr,
  input wire logic [addr_assign_pkg::ADDR_W-1:0] frameAddr,
  // Chain transmitter, pins and device address
  output logic chainTxEn,
  input wire logic [addr_assign_pkg::PIN_COUNT-1:0] strapPins,
  output logic [addr_assign_pkg::PIN_COUNT-1:0] pinForceInput,
  output logic [addr_assign_pkg::ADDR_W-1:0] deviceAddress
);
  import addr_assign_pkg::*;

  logic rstMetaQ;
  logic rstN;
  logic waitReqQ;
  logic [31:0] readDataQ;
  logic [PIN_COUNT-1:0] pinSync;
  logic [ADDR_W-1:0] storedAddrQ;
  logic [ADDR_W-1:0] userAddrQ;
  logic [ADDR_W-1:0] statusQ;
  logic [CFG_ROLE_W-1:0] roleQ;
  logic pinSelQ;
  logic [PIN_COUNT-1:0] pinEnQ;
  logic writeEnQ;
  logic loadPendingQ;
  logic txEnQ;
  addr_state_t stateQ;
  logic busReq;
  logic accept;
  logic wrAcc;
  logic [31:0] ctlWord;
  logic setWriteEn;
  logic reloadReq;
  logic autoDone;

  function automatic logic [31:0] laneMerge(input logic [31:0] old,
                                            input logic [31:0] data,
                                            input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
        res[i*8 +: 8] = data[i*8 +: 8];
    end
    return res;
  endfunction

  function automatic logic wrHit(input logic acc, input logic [7:0] ofs,
                                 input logic [7:0] target);
    return acc && (ofs == target);
  endfunction

  // Reset release through two flops
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rstMetaQ <= 1'b0;
      rstN <= 1'b0;
    end
    else
    begin
      rstMetaQ <= 1'b1;
      rstN <= rstMetaQ;
    end
  end

  sync_two_ff #(
    .WIDTH(PIN_COUNT)
  ) pinSyncInst (
    .clk(sys_clk),
    .rstN(rstN),
    .asyncIn(strapPins),
    .syncOut(pinSync)
  );

  // One wait cycle per access; the request completes when waitReqQ is low
  assign busReq = read || write;
  assign accept = busReq && !waitReqQ;
  assign wrAcc = write && accept;
  assign ctlWord = laneMerge(32'h0000_0000, writedata, byteenable);
  assign setWriteEn = wrHit(wrAcc, address, OFS_CONTROL_ONE) && ctlWord[CTL_WRITE_EN_BIT];
  assign reloadReq = wrHit(wrAcc, address, OFS_CONTROL_ONE) && ctlWord[CTL_RELOAD_BIT];
  assign autoDone = (stateQ == ST_AUTO_WAIT) && frameEnd;

  always_ff @(posedge sys_clk or negedge rstN)
  begin
    if (!rstN)
      waitReqQ <= 1'b1;
    else
      waitReqQ <= !(busReq && waitReqQ);
  end

  always_ff @(posedge sys_clk or negedge rstN)
  begin
    if (!rstN)
      readDataQ <= 32'h0000_0000;
    else if (read && waitReqQ)
    begin
      case (address)
        OFS_STORED_ADDR: readDataQ <= {26'h000_0000, storedAddrQ};
        OFS_USER_ADDR: readDataQ <= {26'h000_0000, userAddrQ};
        OFS_CONTROL_ONE: readDataQ <= {31'h0000_0000, writeEnQ};
        OFS_CONFIG: readDataQ <= {23'h00_0000, pinSelQ, roleQ};
        OFS_PIN_CONFIG: readDataQ <= {26'h000_0000, pinEnQ};
        OFS_ADDR_STATUS: readDataQ <= {22'h00_0000, writeEnQ, txEnQ, 2'h0, statusQ};
        default: readDataQ <= 32'h0000_0000;
      endcase
    end
  end

  // Stored address field; software may save a captured address here
  always_ff @(posedge sys_clk or negedge rstN)
  begin
    if (!rstN)
      storedAddrQ <= STORED_INIT;
    else if (wrHit(wrAcc, address, OFS_STORED_ADDR) && byteenable[0])
      storedAddrQ <= writedata[ADDR_W-1:0];
  end

  always_ff @(posedge sys_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      roleQ <= ROLE_RESET;
      pinSelQ <= PIN_SEL_RESET;
      pinEnQ <= PIN_EN_RESET;
    end
    else
    begin
      if (wrHit(wrAcc, address, OFS_CONFIG))
      begin
        if (byteenable[0])
          roleQ <= writedata[CFG_ROLE_LSB +: CFG_ROLE_W];
        if (byteenable[1])
          pinSelQ <= writedata[CFG_PIN_SEL_BIT];
      end
      if (wrHit(wrAcc, address, OFS_PIN_CONFIG) && byteenable[0])
        pinEnQ <= writedata[PIN_COUNT-1:0];
    end
  end

  // Addressing state machine
  always_ff @(posedge sys_clk or negedge rstN)
  begin
    if (!rstN)
      stateQ <= ST_IDLE;
    else
    begin
      case (stateQ)
        ST_IDLE:
        begin
          if (writeEnQ && !pinSelQ)
            stateQ <= ST_AUTO_WAIT;
          else if (writeEnQ && pinSelQ)
            stateQ <= ST_PIN_SAMPLE;
        end
        ST_AUTO_WAIT:
        begin
          if (frameEnd)
            stateQ <= ST_IDLE;
        end
        ST_PIN_SAMPLE:
          stateQ <= ST_IDLE;
        default:
          stateQ <= ST_IDLE;
      endcase
    end
  end

  // Write enable: software sets, the block clears; a set in the same cycle wins
  always_ff @(posedge sys_clk or negedge rstN)
  begin
    if (!rstN)
      writeEnQ <= 1'b0;
    else if (setWriteEn)
      writeEnQ <= 1'b1;
    // self-clear on the frame or after sampling
    else if (autoDone || stateQ == ST_PIN_SAMPLE)
      writeEnQ <= 1'b0;
  end

  // transmitter off for exactly the frame being awaited
  always_ff @(posedge sys_clk or negedge rstN)
  begin
    if (!rstN)
      txEnQ <= 1'b1;
    else if (stateQ == ST_IDLE && writeEnQ && !pinSelQ)
      txEnQ <= 1'b0;
    // back on once the enable self-clears
    else if (autoDone)
      txEnQ <= 1'b1;
  end

  // Reset sequence reloads from the stored field one cycle after release
  always_ff @(posedge sys_clk or negedge rstN)
  begin
    if (!rstN)
      loadPendingQ <= 1'b1;
    else
      loadPendingQ <= reloadReq;
  end

  // user field only writable inside the auto window
  always_ff @(posedge sys_clk or negedge rstN)
  begin
    if (!rstN)
      userAddrQ <= STORED_ADDR_RESET;
    else if (loadPendingQ)
      userAddrQ <= storedAddrQ;
    // frame address taken, otherwise the held one stays
    else if (autoDone && frameHasAddr)
      userAddrQ <= frameAddr;
    // writes allowed only while waiting for the frame
    else if (stateQ == ST_AUTO_WAIT && wrHit(wrAcc, address, OFS_USER_ADDR) && byteenable[0])
      userAddrQ <= writedata[ADDR_W-1:0];
    else if (stateQ == ST_PIN_SAMPLE)
      userAddrQ <= pinSync & pinEnQ;
  end

  always_ff @(posedge sys_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      deviceAddress <= STORED_ADDR_RESET;
      statusQ <= STORED_ADDR_RESET;
    end
    else if (loadPendingQ)
    begin
      deviceAddress <= storedAddrQ;
      statusQ <= storedAddrQ;
    end
    else if (autoDone)
    begin
      deviceAddress <= frameHasAddr ? frameAddr : userAddrQ;
      statusQ <= frameHasAddr ? frameAddr : userAddrQ;
    end
    // pin i lands on bit i, disabled pins read zero
    else if (stateQ == ST_PIN_SAMPLE)
    begin
      deviceAddress <= pinSync & pinEnQ;
      statusQ <= pinSync & pinEnQ;
    end
    // pins are not looked at outside the sample cycle
  end

  // enabled pins are forced to input, overriding their function
  always_ff @(posedge sys_clk or negedge rstN)
  begin
    if (!rstN)
      pinForceInput <= PIN_EN_RESET;
    else
      pinForceInput <= pinEnQ;
  end

  assign readdata = readDataQ;
  assign waitrequest = waitReqQ;
  assign chainTxEn = txEnQ;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstN);

  enter_auto_a: assert property (
    (stateQ == ST_IDLE && writeEnQ && !pinSelQ) |=> (stateQ == ST_AUTO_WAIT) && !chainTxEn)
    else $error("auto mode not entered");
  tx_muted_a: assert property (
    (stateQ == ST_AUTO_WAIT) |-> !chainTxEn)
    else $error("transmitter on during address frame");
  self_clear_a: assert property (
    (autoDone && !setWriteEn) |=> !writeEnQ && stateQ == ST_IDLE)
    else $error("write enable not self-cleared");
  addr_take_a: assert property (
    (autoDone && frameHasAddr && !loadPendingQ) |=> deviceAddress == $past(frameAddr))
    else $error("frame address not taken");
  addr_keep_a: assert property (
    (autoDone && !frameHasAddr && !loadPendingQ) |=> deviceAddress == $past(userAddrQ))
    else $error("held address not kept");
  status_copy_a: assert property (
    $changed(deviceAddress) |-> statusQ == deviceAddress)
    else $error("status differs from address");
  tx_back_a: assert property (
    (autoDone && !setWriteEn) |=> chainTxEn [*2])
    else $error("transmitter not re-enabled");
  pin_sample_a: assert property (
    (stateQ == ST_PIN_SAMPLE && !setWriteEn && !loadPendingQ)
      |=> deviceAddress == $past(pinSync & pinEnQ) && !writeEnQ)
    else $error("pin address wrong");
  pin_hold_a: assert property (
    (stateQ == ST_IDLE && !loadPendingQ && !writeEnQ) |=> $stable(deviceAddress))
    else $error("address moved without cause");
  user_lock_a: assert property (
    (stateQ != ST_AUTO_WAIT && !loadPendingQ && stateQ != ST_PIN_SAMPLE) |=> $stable(userAddrQ))
    else $error("user address written while locked");
  reload_a: assert property (
    loadPendingQ |=> deviceAddress == $past(storedAddrQ))
    else $error("stored address not reloaded");

  auto_frame_c: cover property (autoDone && frameHasAddr);
  auto_empty_c: cover property (autoDone && !frameHasAddr);
  pin_mode_c: cover property (stateQ == ST_PIN_SAMPLE && pinEnQ != 6'h00);
  set_clear_c: cover property (autoDone && setWriteEn);
endmodule // addr_assign
`default_nettype wire

/* File: addr_assign_pkg.sv */
/*
  Constants for the chain address assignment block: register offsets,
  field positions, reset values and the state encoding.
  Assumes a 32-bit Avalon-MM register bus with byte addresses.
*/
package addr_assign_pkg;
  localparam int ADDR_W = 6;
  localparam int PIN_COUNT = 6;
  // Register byte offsets
  localparam logic [7:0] OFS_STORED_ADDR = 8'h00;
  localparam logic [7:0] OFS_USER_ADDR = 8'h04;
  localparam logic [7:0] OFS_CONTROL_ONE = 8'h08;
  localparam logic [7:0] OFS_CONFIG = 8'h0C;
  localparam logic [7:0] OFS_PIN_CONFIG = 8'h10;
  localparam logic [7:0] OFS_ADDR_STATUS = 8'h14;
  // Field positions
  localparam int CTL_WRITE_EN_BIT = 0;
  localparam int CTL_RELOAD_BIT = 1;
  localparam int CFG_ROLE_LSB = 0;
  localparam int CFG_ROLE_W = 8;
  localparam int CFG_PIN_SEL_BIT = 8;
  localparam int STAT_TX_EN_BIT = 8;
  localparam int STAT_WRITE_EN_BIT = 9;
  // Reset values
  localparam logic [ADDR_W-1:0] STORED_ADDR_RESET = 6'h00;
  localparam logic [CFG_ROLE_W-1:0] ROLE_RESET = 8'h00;
  localparam logic PIN_SEL_RESET = 1'b0;
  localparam logic [PIN_COUNT-1:0] PIN_EN_RESET = 6'h00;

  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_AUTO_WAIT = 2'b01,
    ST_PIN_SAMPLE = 2'b10
  } addr_state_t;
endpackage

/* File: addr_assign_tb.sv */
/*
  Self-checking bench for the chain address assignment block.
  Assumes the block's register map and one-wait-state bus timing.
*/
`timescale 1ns/1ns
`default_nettype none
module addr_assign_tb;
  import addr_assign_pkg::*;
  localparam logic [ADDR_W-1:0] STORED_V = 6'h15;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] address = 8'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'hF;
  logic [31:0] readdata;
  logic waitrequest;
  logic frameEnd;
  logic frameHasAddr;
  logic [ADDR_W-1:0] frameAddr;
  logic chainTxEn;
  logic [PIN_COUNT-1:0] strapPins = 6'h00;
  logic [PIN_COUNT-1:0] pinForceInput;
  logic [ADDR_W-1:0] deviceAddress;
  logic [31:0] expQ[$];
  logic [31:0] seed = 32'hFE861747;
  int errors = 0;
  int totalChecks = 0;

  addr_assign #(.STORED_INIT(STORED_V)) i_addr_assign (.sys_clk(sys_clk), .reset_n(reset_n),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .frameEnd(frameEnd), .frameHasAddr(frameHasAddr), .frameAddr(frameAddr),
    .chainTxEn(chainTxEn), .strapPins(strapPins), .pinForceInput(pinForceInput),
    .deviceAddress(deviceAddress));
  chain_partner i_chain_partner (.sys_clk(sys_clk), .frameEnd(frameEnd),
    .frameHasAddr(frameHasAddr), .frameAddr(frameAddr));

  initial
  begin
    forever #4 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic xfer(input logic isWr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    address <= a;
    writedata <= d;
    write <= isWr;
    read <= ~isWr;
    // Request stands until waitrequest is sampled low; only the watchdog ends a hang
    do
      @(posedge sys_clk);
    while (waitrequest !== 1'b0);
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    expQ.push_back(exp);
    xfer(1'b0, a, 32'h0);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask

  // Read results are matched to the oldest expectation as they complete
  always @(posedge sys_clk)
  begin
    if (read && !waitrequest)
    begin
      if (expQ.size() == 0)
      begin
        errors++;
        $display("[ERR] %0t unexpected read", $time);
      end
      else
        chk(readdata, expQ.pop_front());
    end
  end

  task automatic tally_and_finish();
    $display("Checks %0d mismatches %0d", totalChecks, errors);
    if (errors == 0 && totalChecks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    #200000;
    errors++;
    $display("[ERR] %0t watchdog expired", $time);
    tally_and_finish();
  end

  initial
  begin
    logic [ADDR_W-1:0] cur;
    logic [PIN_COUNT-1:0] en;
    logic [PIN_COUNT-1:0] pins;
    logic [7:0] roles[3];
    roles = '{8'h00, 8'h02, 8'h03};
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'b1;
    settle(4);
    cur = STORED_V;
    chk({26'h0, deviceAddress}, {26'h0, cur});
    rd(OFS_ADDR_STATUS, 32'h100 | cur);
    rd(8'h20, 32'h0);
    xfer(1'b1, OFS_USER_ADDR, 32'h2A);
    settle(1);
    chk({26'h0, deviceAddress}, {26'h0, cur});
    rd(OFS_USER_ADDR, {26'h0, cur});
    i_chain_partner.send_frame(1'b1, 6'h11);
    settle(2);
    chk({26'h0, deviceAddress}, {26'h0, cur});
    // The last two passes send frames without an address: the held one must stay
    for (int i = 0; i < 4; i++)
    begin
      xfer(1'b1, OFS_CONTROL_ONE, 32'h1);
      settle(2);
      chk({31'h0, chainTxEn}, 32'h0);
      rd(OFS_ADDR_STATUS, 32'h200 | cur);
      if (i < 2)
        cur = ADDR_W'(i);
      else if (i == 2)
      begin
        cur = ADDR_W'(rnd());
        xfer(1'b1, OFS_USER_ADDR, {26'h0, cur});
      end
      i_chain_partner.send_frame(i < 2, ADDR_W'(i));
      settle(2);
      chk({31'h0, chainTxEn}, 32'h1);
      chk({26'h0, deviceAddress}, {26'h0, cur});
      rd(OFS_ADDR_STATUS, 32'h100 | cur);
    end
    foreach (roles[k])
    begin
      xfer(1'b1, OFS_CONFIG, {24'h0, roles[k]});
      rd(OFS_CONFIG, {24'h0, roles[k]});
    end
    for (int i = 0; i < 4; i++)
    begin
      en = PIN_COUNT'(rnd());
      pins = PIN_COUNT'(rnd());
      @(posedge sys_clk);
      strapPins <= pins;
      xfer(1'b1, OFS_PIN_CONFIG, {26'h0, en});
      settle(1);
      chk({26'h0, pinForceInput}, {26'h0, en});
      xfer(1'b1, OFS_CONFIG, 32'h100);
      xfer(1'b1, OFS_CONTROL_ONE, 32'h1);
      settle(4);
      cur = pins & en;
      chk({26'h0, deviceAddress}, {26'h0, cur});
      rd(OFS_ADDR_STATUS, 32'h100 | cur);
      xfer(1'b1, OFS_PIN_CONFIG, 32'h0);
      @(posedge sys_clk);
      strapPins <= ~pins;
      settle(4);
      chk({26'h0, deviceAddress}, {26'h0, cur});
    end
    xfer(1'b1, OFS_CONFIG, 32'h0);
    xfer(1'b1, OFS_STORED_ADDR, 32'h3F);
    rd(OFS_STORED_ADDR, 32'h3F);
    xfer(1'b1, OFS_CONTROL_ONE, 32'h2);
    settle(2);
    chk({26'h0, deviceAddress}, 32'h3F);
    // Mid-run reset: the stored field falls back to its reset value and is reloaded
    @(posedge sys_clk);
    reset_n <= 1'b0;
    settle(1);
    chk({26'h0, deviceAddress}, {26'h0, STORED_ADDR_RESET});
    @(posedge sys_clk);
    reset_n <= 1'b1;
    settle(4);
    chk({26'h0, deviceAddress}, {26'h0, STORED_V});
    rd(OFS_ADDR_STATUS, 32'h100 | STORED_V);
    settle(2);
    tally_and_finish();
  end
endmodule // addr_assign_tb
`default_nettype wire

/* File: chain_partner.sv */
/*
  Far side of the chain receiver: hands the block one frame report at a time.
  Assumes the bench calls send_frame away from the rising clock edge.
*/
`timescale 1ns/1ns
`default_nettype none
module chain_partner
  import addr_assign_pkg::*;
(
  // Clock
  input wire logic sys_clk,
  // Frame report
  output logic frameEnd,
  output logic frameHasAddr,
  output logic [addr_assign_pkg::ADDR_W-1:0] frameAddr
);
  logic req = 1'b0;
  logic reqHas = 1'b0;
  logic [ADDR_W-1:0] reqAddr = '0;
  initial frameEnd = 1'b0;
  initial frameHasAddr = 1'b0;
  initial frameAddr = 6'h2A;
  // One frame per request, sent only when the bench says
  // Between frames the qualifiers churn so stale values are never trusted
  always @(posedge sys_clk)
  begin
    if (req)
    begin
      frameEnd <= 1'b1;
      frameHasAddr <= reqHas;
      frameAddr <= reqAddr;
      req = 1'b0;
    end
    else
    begin
      frameEnd <= 1'b0;
      frameHasAddr <= ~frameHasAddr;
      frameAddr <= ~frameAddr;
    end
  end
  task automatic send_frame(input logic has, input logic [ADDR_W-1:0] a);
    @(negedge sys_clk);
    reqHas = has;
    reqAddr = a;
    req = 1'b1;
    wait (req == 1'b0);
  endtask
endmodule // chain_partner
`default_nettype wire

/* File: sync_two_ff.sv */
/*
  Two flip-flop synchroniser for a vector of independent levels.
  Assumes each bit is a slow static level, such as a strap pin.
*/
`timescale 1ns/1ns
`default_nettype none
module sync_two_ff #(
  parameter int WIDTH = 6
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstN,
  // Levels
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] metaQ;

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      metaQ <= '0;
      syncOut <= '0;
    end
    else
    begin
      metaQ <= asyncIn;
      syncOut <= metaQ;
    end
  end
endmodule // sync_two_ff
`default_nettype wire
